// ==== flash_cmd_device.sv ====
// device end: latch, identity and status readout command logic
//
// Design decisions made here: the placing of the registers and the two-flop synchronisation of the link pins.
`timescale 1ns/1ps
`include "flash_link_params.svh"
module flash_cmd_device #(
    parameter logic [7:0] MANUF_CODE = 8'hA5,     // arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h5A,      // arbitrary value
    parameter logic [7:0] CAPACITY_CODE = 8'h3C,  // arbitrary value
    parameter logic [127:0] CUSTOM_BYTES = '0,
    parameter logic [2:0] GUARD_INIT = 3'h0,
    parameter logic FREEZE_INIT = 1'b0
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // serial link
    flash_link_if.device lnk,
    // write-protect pin, active low
    input wire logic wp_n,
    // internal cycle and lock state from the array logic
    input wire logic busy_in,
    input wire logic op_done,
    input wire logic lock_all_set,
    // status store request from the status-write logic
    input wire logic store_req,
    input wire logic [7:0] store_data,
    output logic store_refused,
    // protection view
    output logic write_latch_flag,
    output logic [7:0] status_flags,
    output logic hard_lock_state,
    output logic modify_allowed,
    output logic area_guarded,
    output logic bulk_allowed
);
    import flash_link_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge detection

    logic [3:0] pins_s;
    logic sclk_s;
    logic cs_s;
    logic mosi_s;
    logic wp_s;

    pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        // select and protect pass inverted so the reset value reads as idle
        .d({lnk.sclk, ~lnk.cs_n, lnk.mosi, ~wp_n}),
        .q(pins_s)
    );

    assign {sclk_s, cs_s, mosi_s, wp_s} = pins_s ^ 4'h5;

    dev_state_t st;
    dev_state_t next_st;
    logic rise;
    logic fall;
    logic [7:0] code;
    logic [7:0] flags;
    logic hard_lock;

    assign rise = sclk_s & ~st.sclk_q;
    assign fall = ~sclk_s & st.sclk_q;
    assign code = {st.shift_in[6:0], mosi_s};
    assign hard_lock = st.freeze & ~wp_s;
    assign flags = {st.freeze, 2'b00, st.guard, st.latch, busy_in};

    ////////////////////////////////////////////////////////////////////////
    // identity byte table

    function automatic logic [7:0] id_byte(input logic [4:0] idx);
        logic [127:0] sh;
        logic [4:0] rel;
        rel = 5'(idx - `ID_IDX_CUSTOM);
        sh = CUSTOM_BYTES << {rel[3:0], 3'b000};
        case (idx)
            `ID_IDX_MANUF: id_byte = MANUF_CODE;
            `ID_IDX_TYPE: id_byte = TYPE_CODE;
            `ID_IDX_CAP: id_byte = CAPACITY_CODE;
            `ID_IDX_LEN: id_byte = `ID_LEN_BYTE;
            default:
            begin
                if (idx >= `ID_IDX_CUSTOM && idx <= `ID_IDX_LAST)
                    id_byte = sh[127:120];
                else
                    id_byte = 8'h00;
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_st = st;
        next_st.sclk_q = sclk_s;
        next_st.refused = 1'b0;

        // completion of a modifying cycle drops the latch
        if (op_done)
            next_st.latch = 1'b0;

        // status store from the status-write logic
        if (store_req)
        begin
            if (st.latch && !hard_lock && !busy_in)
            begin
                next_st.freeze = store_data[7];
                next_st.guard = store_data[4:2];
            end
            else
                next_st.refused = 1'b1;
        end

        if (cs_s)
        begin
            // deselect: bare codes act only on an exact byte
            if (st.mode == DEV_BARE && st.bit_cnt == `BARE_BITS)
            begin
                if (st.shift_in == `OP_LATCH_SET)
                    next_st.latch = 1'b1;
                else
                    next_st.latch = 1'b0;
            end
            next_st.mode = DEV_IDLE;
            next_st.miso_oe = 1'b0;
            next_st.bit_cnt = 4'h0;
        end
        else
        begin
            if (st.mode == DEV_IDLE)
                next_st.mode = DEV_CMD;
            if (rise)
            begin
                if (st.bit_cnt != `BIT_CNT_MAX)
                    next_st.bit_cnt = st.bit_cnt + 4'h1;
                next_st.shift_in = code;
            end
            if (rise && (st.mode == DEV_IDLE || st.mode == DEV_CMD)
                && st.bit_cnt == `LAST_CODE_BIT)
            begin
                next_st.out_cnt = 3'h0;
                next_st.byte_idx = `ID_IDX_MANUF;
                case (code)
                    `OP_READ_IDENTITY:
                    begin
                        next_st.mode = busy_in ? DEV_IGNORE : DEV_ID_OUT;
                        next_st.out_shift = id_byte(`ID_IDX_MANUF);
                    end
                    `OP_READ_FLAGS:
                    begin
                        next_st.mode = DEV_FLAGS_OUT;
                        next_st.out_shift = flags;
                    end
                    `OP_LATCH_SET, `OP_LATCH_CLEAR:
                        next_st.mode = DEV_BARE;
                    default:
                        next_st.mode = DEV_IGNORE;
                endcase
            end
            else if (fall && (st.mode == DEV_ID_OUT || st.mode == DEV_FLAGS_OUT))
            begin
                next_st.miso_oe = 1'b1;
                next_st.miso = st.out_shift[7];
                next_st.out_cnt = st.out_cnt + 3'h1;
                if (st.out_cnt == 3'h7)
                begin
                    if (st.mode == DEV_FLAGS_OUT)
                        next_st.out_shift = flags;
                    else
                    begin
                        if (st.byte_idx != `ID_IDX_LAST + 5'h1)
                            next_st.byte_idx = st.byte_idx + 5'h1;
                        next_st.out_shift = id_byte(st.byte_idx + 5'h1);
                    end
                end
                else
                    next_st.out_shift = {st.out_shift[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.mode <= DEV_IDLE;
            st.latch <= 1'b0;
            st.freeze <= FREEZE_INIT;
            st.guard <= GUARD_INIT;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign lnk.miso_drv = st.miso;
    assign lnk.miso_oe = st.miso_oe;
    assign store_refused = st.refused;
    assign write_latch_flag = st.latch;
    assign status_flags = flags;
    assign hard_lock_state = hard_lock;
    assign modify_allowed = st.latch & ~busy_in;
    assign area_guarded = |st.guard;
    assign bulk_allowed = st.latch & (st.guard == 3'h0) & ~lock_all_set;
endmodule

// ==== flash_cmd_host.sv ====
// host end: register-driven serial instruction sequencer over AXI4-Lite
`timescale 1ns/1ps
`include "flash_link_params.svh"
module flash_cmd_host #(
    parameter int HALF = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // serial link
    flash_link_if.host lnk,
    // write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address and data
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import flash_link_pkg::*;

    logic miso_s;
    host_state_t st;
    host_state_t next_st;
    logic tick;
    logic busy;
    logic [11:0] total;

    pin_sync #(
        .WIDTH(1)
    ) u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .d(lnk.miso),
        .q(miso_s)
    );

    assign tick = st.div_cnt == 8'(HALF - 1);
    assign busy = st.phase != HOST_IDLE;
    assign total = {1'b0, st.nbytes, 3'b000} + 12'h008;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        next_st = st;
        next_st.div_cnt = st.div_cnt + 8'h01;

        // register writes: address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata;
            // strobes are only valid beside wvalid, so keep them with the data
            next_st.wstrb = s_axi_wstrb[1:0];
        end
        if (s_axi_bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;
        if (st.aw_held && st.w_held)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `RESP_OKAY;
            if (st.awaddr == `REG_COMMAND)
            begin
                // a command written while busy is dropped
                if (!busy && st.wstrb[0])
                begin
                    next_st.phase = HOST_LOW;
                    next_st.cs_n = 1'b0;
                    next_st.tx = st.wdata[7:0];
                    next_st.mosi = st.wdata[7];
                    next_st.nbytes = st.wstrb[1] ? st.wdata[15:8] : 8'h00;
                    next_st.rise_cnt = 12'h000;
                    next_st.div_cnt = 8'h00;
                end
            end
            else if (st.awaddr != `REG_STATUS && st.awaddr != `REG_RXDATA)
                next_st.bresp = `RESP_SLVERR;
        end

        // register reads
        if (s_axi_rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = `RESP_OKAY;
            case (s_axi_araddr)
                `REG_COMMAND: next_st.rdata = {16'h0000, st.nbytes, st.tx};
                `REG_STATUS: next_st.rdata = {31'h0000_0000, busy};
                `REG_RXDATA: next_st.rdata = st.rx;
                default:
                begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = `RESP_SLVERR;
                end
            endcase
        end

        // serial sequencer, clock low then high per bit
        case (st.phase)
            HOST_IDLE:
                next_st.div_cnt = 8'h00;
            HOST_LOW:
                if (tick)
                begin
                    next_st.sclk = 1'b1;
                    next_st.rise_cnt = st.rise_cnt + 12'h001;
                    next_st.phase = HOST_HIGH;
                    next_st.div_cnt = 8'h00;
                end
            HOST_HIGH:
                if (tick)
                begin
                    next_st.sclk = 1'b0;
                    next_st.div_cnt = 8'h00;
                    // bit driven one falling edge earlier is settled here
                    if (st.rise_cnt >= `FIRST_DATA_RISE)
                        next_st.rx = {st.rx[30:0], miso_s};
                    next_st.tx = {st.tx[6:0], 1'b0};
                    next_st.mosi = st.tx[6];
                    next_st.phase = (st.rise_cnt == total) ? HOST_TAIL : HOST_LOW;
                end
            HOST_TAIL:
                if (st.div_cnt == 8'(2 * HALF - 1))
                begin
                    // last data bit was already taken at the final falling edge
                    next_st.cs_n = 1'b1;
                    next_st.phase = HOST_GAP;
                    next_st.div_cnt = 8'h00;
                end
            HOST_GAP:
                if (tick)
                    next_st.phase = HOST_IDLE;
            default:
                next_st.phase = HOST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.phase <= HOST_IDLE;
            st.cs_n <= 1'b1;
        end
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign lnk.sclk = st.sclk;
    assign lnk.cs_n = st.cs_n;
    assign lnk.mosi = st.mosi;
    assign s_axi_awready = ~st.aw_held & ~st.bvalid;
    assign s_axi_wready = ~st.w_held & ~st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = ~st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
endmodule

// ==== flash_latch_id_status_logic_bench.sv ====
// self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
`include "flash_link_params.svh"
module flash_latch_id_status_logic_bench;
    localparam logic [7:0] MANUF = 8'h3E;  // arbitrary value
    localparam logic [7:0] DTYPE = 8'hC1;  // arbitrary value
    localparam logic [7:0] CAP = 8'h77;    // arbitrary value
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic wp_n = 1'b1, busy_in = 1'b0, op_done = 1'b0, lock_all_set = 1'b0, store_req = 1'b0;
    logic [7:0] store_data = 8'h00;
    logic store_refused, write_latch_flag, hard_lock_state, modify_allowed;
    logic area_guarded, bulk_allowed;
    logic [7:0] status_flags;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] resp;
    logic r;
    int mismatches = 0;
    int samples_checked = 0;

    always #12.5 clock = ~clock;

    flash_link_if link();
    flash_cmd_device #(.MANUF_CODE(MANUF), .TYPE_CODE(DTYPE), .CAPACITY_CODE(CAP))
    i_flash_cmd_device (.clock(clock), .arst_n(arst_n), .lnk(link.device), .wp_n(wp_n),
        .busy_in(busy_in), .op_done(op_done), .lock_all_set(lock_all_set),
        .store_req(store_req), .store_data(store_data), .store_refused(store_refused),
        .write_latch_flag(write_latch_flag), .status_flags(status_flags),
        .hard_lock_state(hard_lock_state), .modify_allowed(modify_allowed),
        .area_guarded(area_guarded), .bulk_allowed(bulk_allowed));
    flash_cmd_host #(.HALF(4)) i_flash_cmd_host (.clock(clock), .arst_n(arst_n),
        .lnk(link.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    flash_link_props i_flash_link_props (.clock(clock), .arst_n(arst_n), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .miso_drv(link.miso_drv),
        .miso_oe(link.miso_oe), .miso(link.miso));

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] v);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge clock);
            if (awvalid && awready && !ad)
            begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready && !wd)
            begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid)
            @(posedge clock);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task rd(input logic [3:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // issue one instruction and wait until the host is idle again
    task cmd(input logic [15:0] c);
        wr(`REG_COMMAND, {16'h0000, c});
        do rd(`REG_STATUS); while (d[0] !== 1'b0);
        repeat (8) @(posedge clock);
    endtask

    task store(input logic [7:0] v);
        @(posedge clock);
        store_req <= 1'b1;
        store_data <= v;
        @(posedge clock);
        store_req <= 1'b0;
        // refusal pulse launched at the previous edge still stands here
        @(posedge clock);
        r = store_refused;
    endtask

    task stop_test;
        $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    initial
    begin
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk(write_latch_flag, 0);
        chk(status_flags, 32'h0000_0000);
        cmd(16'h0106);
        chk(write_latch_flag, 0);
        cmd(16'h0006);
        chk(write_latch_flag, 1);
        chk(modify_allowed, 1);
        cmd(16'h0205);
        rd(`REG_RXDATA);
        chk(d[15:0], 32'h0000_0202);
        busy_in <= 1'b1;
        cmd(16'h0105);
        rd(`REG_RXDATA);
        chk(d[7:0], 32'h0000_0003);
        chk(modify_allowed, 0);
        cmd(16'h049F);
        rd(`REG_RXDATA);
        chk(d, 32'h0000_0000);
        busy_in <= 1'b0;
        cmd(16'h049F);
        rd(`REG_RXDATA);
        chk(d, {MANUF, DTYPE, CAP, 8'h10});
        cmd(16'h149F);
        rd(`REG_RXDATA);
        chk(d, 32'h0000_0000);
        cmd(16'h0004);
        chk(write_latch_flag, 0);
        cmd(16'h0006);
        @(posedge clock);
        op_done <= 1'b1;
        @(posedge clock);
        op_done <= 1'b0;
        repeat (2) @(posedge clock);
        chk(write_latch_flag, 0);
        cmd(16'h0006);
        store(8'h9C);
        chk(r, 0);
        chk(status_flags & 8'hFC, 32'h0000_009C);
        chk(area_guarded, 1);
        chk(bulk_allowed, 0);
        wp_n <= 1'b0;
        repeat (4) @(posedge clock);
        chk(hard_lock_state, 1);
        cmd(16'h0006);
        store(8'h00);
        chk(r, 1);
        chk(status_flags & 8'hFC, 32'h0000_009C);
        wp_n <= 1'b1;
        repeat (4) @(posedge clock);
        cmd(16'h0006);
        store(8'h00);
        chk(r, 0);
        chk(status_flags & 8'hFC, 32'h0000_0000);
        cmd(16'h0006);
        chk(bulk_allowed, 1);
        lock_all_set <= 1'b1;
        @(posedge clock);
        #1 chk(bulk_allowed, 0);
        rd(4'hC);
        chk(resp, `RESP_SLVERR);
        stop_test();
    end
endmodule

// ==== flash_link_if.sv ====
// serial link between the flash command logic and its host
`timescale 1ns/1ps
interface flash_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_drv;
    logic miso_oe;
    logic miso;

    // undriven data line reads low
    assign miso = miso_oe ? miso_drv : 1'b0;

    modport device (input sclk, input cs_n, input mosi, output miso_drv, output miso_oe);
    modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ==== flash_link_params.svh ====
// constants shared by both ends of the serial flash command link
`ifndef FLASH_LINK_PARAMS_SVH
`define FLASH_LINK_PARAMS_SVH
// instruction codes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_READ_IDENTITY 8'h9F
`define OP_READ_FLAGS 8'h05
// identity readout
`define ID_LEN_BYTE 8'h10
`define ID_IDX_MANUF 5'h00
`define ID_IDX_TYPE 5'h01
`define ID_IDX_CAP 5'h02
`define ID_IDX_LEN 5'h03
`define ID_IDX_CUSTOM 5'h04
`define ID_IDX_LAST 5'h13
// bit counts on the link
`define BARE_BITS 4'h8
`define LAST_CODE_BIT 4'h7
`define BIT_CNT_MAX 4'hF
`define FIRST_DATA_RISE 12'h009
// host register map, byte offsets
`define REG_COMMAND 4'h0
`define REG_STATUS 4'h4
`define REG_RXDATA 4'h8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== flash_link_pkg.sv ====
// state types of both ends of the serial flash command link
package flash_link_pkg;
    typedef enum logic [2:0] {
        DEV_IDLE = 3'b000,
        DEV_CMD = 3'b001,
        DEV_ID_OUT = 3'b010,
        DEV_FLAGS_OUT = 3'b011,
        DEV_BARE = 3'b100,
        DEV_IGNORE = 3'b101
    } dev_mode_t;

    typedef enum logic [2:0] {
        HOST_IDLE = 3'b000,
        HOST_LOW = 3'b001,
        HOST_HIGH = 3'b010,
        HOST_TAIL = 3'b011,
        HOST_GAP = 3'b100
    } host_phase_t;

    typedef struct packed {
        dev_mode_t mode;
        logic sclk_q;
        logic [3:0] bit_cnt;
        logic [7:0] shift_in;
        logic [7:0] out_shift;
        logic [2:0] out_cnt;
        logic [4:0] byte_idx;
        logic miso;
        logic miso_oe;
        logic latch;
        logic freeze;
        logic [2:0] guard;
        logic refused;
    } dev_state_t;

    typedef struct packed {
        host_phase_t phase;
        logic [7:0] div_cnt;
        logic sclk;
        logic cs_n;
        logic mosi;
        logic [7:0] tx;
        logic [7:0] nbytes;
        logic [11:0] rise_cnt;
        logic [31:0] rx;
        logic aw_held;
        logic [3:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } host_state_t;
endpackage

// ==== flash_link_props.sv ====
// concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
module flash_link_props (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso_drv,
    input wire logic miso_oe,
    input wire logic miso
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    ////////////////////////////////////////////////////////////////////////
    property p_oe_off_deselected;
        cs_n [*5] |-> !miso_oe;
    endproperty
    a_oe_off_deselected: assert property (p_oe_off_deselected)
        else $error("data line still driven while deselected");

    property p_out_on_low_clock;
        miso_oe && $past(miso_oe) && $changed(miso_drv) |-> !sclk;
    endproperty
    a_out_on_low_clock: assert property (p_out_on_low_clock)
        else $error("output bit changed while serial clock high");

    property p_oe_start;
        $rose(miso_oe) |-> !cs_n && !sclk;
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("output enabled outside a selected low clock phase");

    property p_cs_gap;
        $rose(cs_n) |=> cs_n [*3];
    endproperty
    a_cs_gap: assert property (p_cs_gap)
        else $error("chip select high for too short a gap");

    property p_clock_idle;
        cs_n |-> !sclk;
    endproperty
    a_clock_idle: assert property (p_clock_idle)
        else $error("serial clock high while deselected");

    property p_high_phase;
        $rose(sclk) |=> sclk [*3] ##1 !sclk;
    endproperty
    a_high_phase: assert property (p_high_phase)
        else $error("serial clock high phase length wrong");

    property p_mosi_stable;
        sclk && $past(sclk) |-> $stable(mosi);
    endproperty
    a_mosi_stable: assert property (p_mosi_stable)
        else $error("host data changed while serial clock high");

    property p_no_out_in_code;
        $fell(cs_n) |-> ##3 !miso_oe [*8];
    endproperty
    a_no_out_in_code: assert property (p_no_out_in_code)
        else $error("device drove data during the code byte");
endmodule

// ==== pin_sync.sv ====
// two-flop synchroniser for a group of pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // pins and their synchronised copies
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb
    begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign q = st.s2;
endmodule
